// File: src/eth_mac_tx_stream_client.sv
`timescale 1ns/1ps
`include "eth_tx_map.svh"
module eth_mac_tx_stream_client
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [`DATA_W-1:0] tx_axis_tdata,
    input wire logic [`KEEP_W-1:0] tx_axis_tkeep,
    input wire logic tx_axis_tvalid,
    input wire logic tx_axis_tuser,
    input wire logic tx_axis_tlast,
    output logic tx_axis_tready,
    input wire logic [7:0] tx_ifg_delay,
    input wire logic idle_deficit_averaging,
    input wire logic inband_fcs_en,
    input wire logic ifg_adjust_en,
    output logic [7:0] tx_byte,
    output logic tx_byte_ctrl,
    output logic [1:0] tx_lane
);
    // Byte-wide reflected CRC step
    function automatic logic [31:0] crc_step(
        input logic [31:0] crc,
        input logic [7:0] din
    );
        logic [31:0] c;
        c = crc ^ {24'h000000, din};
        for (int i = 0; i < 8; i++)
        begin
            c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_step

    stream_if #(.W(`PAY_W)) client_s ();
    stream_if #(.W(`PAY_W)) eng_s ();

    eth_tx_pkg::tx_state_t state_reg;
    eth_tx_pkg::tx_state_t state_next;
    logic [2:0] lane_reg;
    logic [2:0] pre_idx_reg;
    logic [1:0] fcs_idx_reg;
    logic [1:0] pos_reg;
    logic [10:0] byte_cnt_reg;
    logic [9:0] idle_cnt_reg;
    logic [1:0] deficit_reg;
    logic [1:0] deficit_next;
    logic err_reg;
    logic [31:0] crc_reg;
    logic [7:0] byte_next;
    logic ctrl_next;

    logic [`DATA_W-1:0] w_data;
    logic [`KEEP_W-1:0] w_keep;
    logic w_last;
    logic w_user;
    logic [7:0] cur_byte;
    logic more_lanes;
    logic word_end;
    logic [10:0] min_len;
    logic [10:0] cnt_inc;
    logic [9:0] ifg_want;
    logic [9:0] ifg_target;
    logic [9:0] shortfall;
    logic [9:0] surplus;
    logic [9:0] credit;
    logic go;

    // RULE3: single clock domain
    // Client handshake enters the buffer directly on ref_clk
    // RULE5: lane packing
    assign client_s.payload = {tx_axis_tuser, tx_axis_tlast, tx_axis_tkeep, tx_axis_tdata};
    assign client_s.valid = tx_axis_tvalid;
    // RULE9: ready withheld when buffer full
    assign tx_axis_tready = client_s.ready;

    // Buffer decouples client bursts from the byte engine
    stream_fifo #(
        .WIDTH(`PAY_W),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_s(client_s),
        .out_s(eng_s)
    );

    // RULE2: fixed 64-bit, 8-lane path
    // Buffered word fields
    assign w_data = eng_s.payload[`DATA_W-1:0];
    assign w_keep = eng_s.payload[`DATA_W+`KEEP_W-1:`DATA_W];
    assign w_last = eng_s.payload[`PAY_W-2];
    assign w_user = eng_s.payload[`PAY_W-1];

    // RULE5: lane n is bits 8n+7:8n
    assign cur_byte = w_data[{lane_reg, 3'b000} +: 8];
    assign more_lanes = (lane_reg != 3'h7) && w_keep[lane_reg + 3'h1];
    // RULE12: lanes after the last flagged one ignored
    assign word_end = w_last ? !more_lanes : (lane_reg == 3'h7);
    // RULE13: word consumed only when fully sent
    assign eng_s.ready = (state_reg == eth_tx_pkg::ST_DATA) && eng_s.valid && word_end;

    // RULE16: pad floor without in-band FCS
    // RULE17: pad floor counts client FCS
    assign min_len = inband_fcs_en ? `MIN_WITH_FCS : `MIN_NO_FCS;
    assign cnt_inc = (byte_cnt_reg == `CNT_SAT) ? byte_cnt_reg : byte_cnt_reg + 11'h001;

    // RULE7: gap extension counts 4-byte columns
    assign ifg_want = ifg_adjust_en ? {tx_ifg_delay, 2'b00} : `MIN_IFG;
    assign ifg_target = (ifg_want < `MIN_IFG) ? `MIN_IFG : ifg_want;
    assign shortfall = ifg_target - idle_cnt_reg;
    assign surplus = idle_cnt_reg - ifg_target;
    assign credit = {8'h00, 2'h3 - deficit_reg};

    // Start decision and deficit bookkeeping
    always_comb
    begin
        go = 1'b0;
        deficit_next = deficit_reg;
        // RULE20: start only on a 4-byte boundary
        if ((state_reg == eth_tx_pkg::ST_IDLE) && eng_s.valid && (pos_reg == 2'h0))
        begin
            if (idle_cnt_reg >= ifg_target)
            begin
                go = 1'b1;
                // Extra idles repay earlier shortening
                if (surplus >= {8'h00, deficit_reg})
                    deficit_next = 2'h0;
                else
                    deficit_next = deficit_reg - surplus[1:0];
            end
            // RULE1: shorten only within remaining credit, 3 less the deficit
            else if (idle_deficit_averaging && (shortfall <= credit))
            begin
                go = 1'b1;
                deficit_next = deficit_reg + shortfall[1:0];
            end
        end
    end

    // Next state and next output byte
    always_comb
    begin
        state_next = state_reg;
        byte_next = `CH_IDLE;
        ctrl_next = 1'b1;
        case (state_reg)
            eth_tx_pkg::ST_IDLE:
            begin
                if (go)
                begin
                    // RULE19: start character opens the preamble
                    byte_next = `CH_START;
                    state_next = eth_tx_pkg::ST_PRE;
                end
            end
            eth_tx_pkg::ST_PRE:
            begin
                // RULE19: preamble then delimiter
                ctrl_next = 1'b0;
                byte_next = (pre_idx_reg == `PRE_LAST) ? `SFD_BYTE : `PRE_BYTE;
                if (pre_idx_reg == `PRE_LAST)
                    state_next = eth_tx_pkg::ST_DATA;
            end
            eth_tx_pkg::ST_DATA:
            begin
                if (!eng_s.valid)
                begin
                    // Buffer ran dry mid-frame: poison the byte
                    byte_next = `CH_ERR;
                end
                else
                begin
                    // RULE6: explicit underrun corrupts the frame
                    ctrl_next = err_reg || w_user;
                    byte_next = ctrl_next ? `CH_ERR : cur_byte;
                    if (word_end && w_last)
                    begin
                        if (cnt_inc < min_len)
                            state_next = eth_tx_pkg::ST_PAD;
                        else if (inband_fcs_en)
                            state_next = eth_tx_pkg::ST_TERM;
                        else
                            state_next = eth_tx_pkg::ST_FCS;
                    end
                end
            end
            eth_tx_pkg::ST_PAD:
            begin
                // RULE16: zero pad up to minimum
                ctrl_next = 1'b0;
                byte_next = 8'h00;
                if (cnt_inc >= min_len)
                    state_next = inband_fcs_en ? eth_tx_pkg::ST_TERM : eth_tx_pkg::ST_FCS;
            end
            eth_tx_pkg::ST_FCS:
            begin
                // RULE18: inverted CRC, low byte first
                ctrl_next = err_reg;
                byte_next = err_reg ? `CH_ERR : ~crc_reg[7:0];
                if (fcs_idx_reg == 2'h3)
                    state_next = eth_tx_pkg::ST_TERM;
            end
            eth_tx_pkg::ST_TERM:
            begin
                byte_next = `CH_TERM;
                state_next = eth_tx_pkg::ST_IDLE;
            end
            default:
            begin
                state_next = eth_tx_pkg::ST_IDLE;
            end
        endcase
    end

    // RULE4: state machine held in reset
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            state_reg <= eth_tx_pkg::ST_IDLE;
        else
            state_reg <= state_next;
    end

    // Output byte is registered
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            tx_byte <= `CH_IDLE;
            tx_byte_ctrl <= 1'b1;
        end
        else
        begin
            tx_byte <= byte_next;
            tx_byte_ctrl <= ctrl_next;
        end
    end

    // RULE20: byte position within the 4-byte column
    // Leads tx_lane by one, so lane 0 is never shown twice after reset
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            pos_reg <= 2'h1;
        else
            pos_reg <= pos_reg + 2'h1;
    end
    // Column lane of the byte now on tx_byte
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            tx_lane <= 2'h0;
        else
            tx_lane <= pos_reg;
    end

    // Lane walk inside the current buffered word
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            lane_reg <= 3'h0;
        else if (state_reg != eth_tx_pkg::ST_DATA)
            lane_reg <= 3'h0;
        else if (eng_s.valid)
            lane_reg <= word_end ? 3'h0 : lane_reg + 3'h1;
    end

    // Preamble and FCS byte indices
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            pre_idx_reg <= 3'h0;
            fcs_idx_reg <= 2'h0;
        end
        else
        begin
            pre_idx_reg <= (state_reg == eth_tx_pkg::ST_PRE) ? pre_idx_reg + 3'h1 : 3'h0;
            fcs_idx_reg <= (state_reg == eth_tx_pkg::ST_FCS) ? fcs_idx_reg + 2'h1 : 2'h0;
        end
    end

    // Frame byte count; saturates so long frames never wrap into padding
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            byte_cnt_reg <= 11'h000;
        else if (state_reg == eth_tx_pkg::ST_PRE)
            byte_cnt_reg <= 11'h000;
        else if (state_reg == eth_tx_pkg::ST_PAD)
            byte_cnt_reg <= cnt_inc;
        else if ((state_reg == eth_tx_pkg::ST_DATA) && eng_s.valid)
            byte_cnt_reg <= cnt_inc;
    end

    // Underrun latch, cleared at the next frame start
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            err_reg <= 1'b0;
        else if (state_reg == eth_tx_pkg::ST_PRE)
            err_reg <= 1'b0;
        else if (state_reg == eth_tx_pkg::ST_DATA)
            err_reg <= err_reg || !eng_s.valid || w_user;
    end

    // RULE18: CRC over addresses, type, data and pad
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            crc_reg <= `CRC_INIT;
        else if (state_reg == eth_tx_pkg::ST_PRE)
            crc_reg <= `CRC_INIT;
        else if ((state_reg == eth_tx_pkg::ST_DATA) && eng_s.valid)
            crc_reg <= crc_step(crc_reg, cur_byte);
        else if (state_reg == eth_tx_pkg::ST_PAD)
            crc_reg <= crc_step(crc_reg, 8'h00);
        else if (state_reg == eth_tx_pkg::ST_FCS)
            crc_reg <= {8'h00, crc_reg[31:8]};
    end

    // Idle count since terminate; starts saturated so the first frame
    // after reset needs no gap
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            idle_cnt_reg <= `IDLE_SAT;
        else if (state_reg == eth_tx_pkg::ST_TERM)
            idle_cnt_reg <= 10'h000;
        else if ((state_reg == eth_tx_pkg::ST_IDLE) && (idle_cnt_reg != `IDLE_SAT))
            idle_cnt_reg <= idle_cnt_reg + 10'h001;
    end

    // RULE1: running deficit keeps the mean gap at target
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            deficit_reg <= 2'h0;
        else if (go)
            deficit_reg <= deficit_next;
    end
endmodule : eth_mac_tx_stream_client

// File: src/eth_tx_map.svh
// Notes on behaviour
// RULE1: With idle deficit averaging on, gaps may shrink below 12 bytes, averaging 12.
// RULE2: Client data path is 64 bits with 8 lanes, or 32 bits with 4; the code has only the fixed 64-bit, 8-lane path.
// RULE3: Every client signal is sampled and driven on the one transmit clock.
// RULE4: Stream path is held in reset while its reset input is low.
// RULE5: Lane n is data bits 8n+7:8n; keep bit n flags lane n valid.
// RULE6: One user sideband bit lets the client flag an explicit underrun.
// RULE7: Eight-bit gap extension input sets the extra gap between packets.
// RULE8: Client raises valid with the first word and keep in one cycle.
// RULE9: Ready acknowledges the word presented now; it may drop to stall.
// RULE10: After valid and ready both high, client presents the next word.
// RULE11: While stalled, client holds data, keep and last unchanged.
// RULE12: Last marks the final word for one cycle; unflagged lanes are ignored.
// RULE13: After the last word, data and keep are invalid until valid returns.
// RULE14: Addresses and length/type travel in-band, first address byte in lane 0.
// RULE15: Source address follows the destination address directly.
// RULE16: Without in-band FCS, frames under 46 data bytes are padded.
// RULE17: With in-band FCS, short frames get pad after the client FCS.
// RULE18: Without in-band FCS, the 32-bit Ethernet CRC is computed and appended.
// RULE19: Preamble and start delimiter are inserted by the transmitter.
// RULE20: Next frame starts on a 4-byte boundary after the gap count.
// RULE21: Client sets all keep bits on every word but the last.
`ifndef ETH_TX_MAP_SVH
`define ETH_TX_MAP_SVH

`define DATA_W 64
`define KEEP_W 8
`define PAY_W 74
`define FIFO_DEPTH 8
`define CH_IDLE 8'h07
`define CH_START 8'hFB
`define CH_TERM 8'hFD
`define CH_ERR 8'hFE
`define PRE_BYTE 8'h55
`define SFD_BYTE 8'hD5
`define PRE_LAST 3'h6
`define MIN_IFG 10'h00C
`define IDLE_SAT 10'h3FF
`define CNT_SAT 11'h7FF
`define MIN_NO_FCS 11'h03C
`define MIN_WITH_FCS 11'h040
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY 32'hEDB88320

`endif

// File: src/eth_tx_pkg.sv
package eth_tx_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_PRE = 3'b001,
        ST_DATA = 3'b010,
        ST_PAD = 3'b011,
        ST_FCS = 3'b100,
        ST_TERM = 3'b101
    } tx_state_t;

endpackage : eth_tx_pkg

// File: src/stream_fifo.sv
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    stream_if.snk in_s,
    stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Full and empty straight from the occupancy count
    assign in_s.ready = (count_reg != DEPTH[AW:0]);
    assign out_s.valid = (count_reg != '0);
    assign out_s.payload = mem_reg[rd_ptr_reg];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    // Storage is written only on an accepted word
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_s.payload;
        end
    end

    // Pointers wrap; depth is a power of two
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule : stream_fifo

// File: src/stream_if.sv
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8);
    logic [W-1:0] payload;
    logic valid;
    logic ready;

    modport src (output payload, output valid, input ready);
    modport snk (input payload, input valid, output ready);
endinterface : stream_if

// File: tb/client_model.sv
`timescale 1ns/1ps
`include "eth_tx_map.svh"
module client_model
(
    input wire logic ref_clk,
    output logic [`DATA_W-1:0] tdata,
    output logic [`KEEP_W-1:0] tkeep,
    output logic tvalid,
    output logic tuser,
    output logic tlast,
    input wire logic tready
);
    bit timed_out;

    initial
    begin
        {tdata, tkeep, tvalid, tuser, tlast} = '0;
    end

    // Frame byte i is base + 7*i; lanes past the end carry junk to be dropped
    // whole frames
    task automatic send(input int len, input logic [7:0] base, input int bad);
        int w, b, n, nw;
        nw = (len + 7) / 8;
        @(posedge ref_clk);
        for (w = 0; w < nw; w++)
        begin
            for (b = 0; b < 8; b++)
            begin
                tdata[8*b+:8] <= (w*8+b < len) ? 8'(base + 7*(w*8+b)) : 8'(8'hA5 ^ b);
                tkeep[b] <= (w*8+b < len);
            end
            tvalid <= 1'b1;
            tlast <= (w == nw - 1);
            tuser <= (w == bad);
            // Hold everything until ready is seen at an edge
            n = 0;
            do @(negedge ref_clk); while (!tready && ++n < 2000);
            if (n >= 2000) timed_out = 1'b1;
            @(posedge ref_clk);
        end
        tvalid <= 1'b0;
        tlast <= 1'b0;
        tuser <= 1'b0;
        tdata <= ~tdata; // Released bus shows a changed pattern
    endtask : send
endmodule : client_model

// File: tb/eth_mac_tx_stream_client_asserts.sv
`timescale 1ns/1ps
`include "eth_tx_map.svh"
module eth_mac_tx_stream_client_asserts
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [`DATA_W-1:0] tx_axis_tdata,
    input wire logic [`KEEP_W-1:0] tx_axis_tkeep,
    input wire logic tx_axis_tvalid,
    input wire logic tx_axis_tuser,
    input wire logic tx_axis_tlast,
    input wire logic tx_axis_tready,
    input wire logic [7:0] tx_ifg_delay,
    input wire logic idle_deficit_averaging,
    input wire logic inband_fcs_en,
    input wire logic ifg_adjust_en,
    input wire logic [7:0] tx_byte,
    input wire logic tx_byte_ctrl,
    input wire logic [1:0] tx_lane
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // Decoded control characters on the byte stream
    wire logic is_start = tx_byte_ctrl && tx_byte == 8'hFB;
    wire logic is_term = tx_byte_ctrl && tx_byte == 8'hFD;
    wire logic is_idle = tx_byte_ctrl && tx_byte == 8'h07;

    property p_reset_idle;
        $rose(nrst) |-> is_idle && tx_lane == 2'h0 && tx_axis_tready;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("output not idle after reset");

    property p_start_lane0;
        is_start |-> tx_lane == 2'h0;
    endproperty
    a_start_lane0: assert property (p_start_lane0) else $error("start not on lane 0");

    property p_lane_step;
        nrst && $past(nrst) |-> tx_lane == 2'($past(tx_lane) + 2'h1);
    endproperty
    a_lane_step: assert property (p_lane_step) else $error("lane count skipped");

    property p_preamble;
        is_start |=> (!tx_byte_ctrl && tx_byte == 8'h55) [*6] ##1 (!tx_byte_ctrl && tx_byte == 8'hD5);
    endproperty
    a_preamble: assert property (p_preamble) else $error("bad preamble");

    property p_full_gap;
        is_term && !idle_deficit_averaging |=> is_idle [*8] ##1 is_idle [*4];
    endproperty
    a_full_gap: assert property (p_full_gap) else $error("gap below twelve");

    property p_short_gap;
        is_term && idle_deficit_averaging |=> is_idle [*8] ##1 is_idle;
    endproperty
    a_short_gap: assert property (p_short_gap) else $error("gap shortened too far");

    property p_ready_stall;
        $fell(tx_axis_tready) |-> $past(tx_axis_tvalid);
    endproperty
    a_ready_stall: assert property (p_ready_stall) else $error("ready dropped without a take");

    property p_ctrl_codes;
        tx_byte_ctrl |-> tx_byte inside {8'h07, 8'hFB, 8'hFD, 8'hFE};
    endproperty
    a_ctrl_codes: assert property (p_ctrl_codes) else $error("unknown control code");

    property p_term_idle;
        is_term |=> is_idle;
    endproperty
    a_term_idle: assert property (p_term_idle) else $error("no idle after terminate");
endmodule : eth_mac_tx_stream_client_asserts

bind eth_mac_tx_stream_client eth_mac_tx_stream_client_asserts chk (.*);

// File: tb/eth_mac_tx_stream_client_tb.sv
`timescale 1ns/1ps
`include "eth_tx_map.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin bad_count++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module eth_mac_tx_stream_client_tb;
    logic ref_clk, nrst, idle_deficit_averaging, inband_fcs_en, ifg_adjust_en;
    logic [`DATA_W-1:0] tx_axis_tdata;
    logic [`KEEP_W-1:0] tx_axis_tkeep;
    logic tx_axis_tvalid, tx_axis_tuser, tx_axis_tlast, tx_axis_tready, tx_byte_ctrl;
    logic [7:0] tx_ifg_delay, tx_byte;
    logic [1:0] tx_lane;
    int bad_count, checks, frames, gap, gap_last, i;
    bit in_frame, saw_full;
    logic [8:0] rx[$], exq[$];

    eth_mac_tx_stream_client DUT (.ref_clk(ref_clk), .nrst(nrst), .tx_axis_tdata(tx_axis_tdata),
        .tx_axis_tkeep(tx_axis_tkeep), .tx_axis_tvalid(tx_axis_tvalid),
        .tx_axis_tuser(tx_axis_tuser), .tx_axis_tlast(tx_axis_tlast),
        .tx_axis_tready(tx_axis_tready), .tx_ifg_delay(tx_ifg_delay),
        .idle_deficit_averaging(idle_deficit_averaging), .inband_fcs_en(inband_fcs_en),
        .ifg_adjust_en(ifg_adjust_en), .tx_byte(tx_byte), .tx_byte_ctrl(tx_byte_ctrl),
        .tx_lane(tx_lane));

    client_model PEER (.ref_clk(ref_clk), .tdata(tx_axis_tdata), .tkeep(tx_axis_tkeep),
        .tvalid(tx_axis_tvalid), .tuser(tx_axis_tuser), .tlast(tx_axis_tlast),
        .tready(tx_axis_tready));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Capture each frame from start to terminate, and idles before it
    always @(posedge ref_clk)
    begin
        if (!tx_axis_tready) saw_full = 1'b1;
        if (nrst && tx_byte_ctrl && tx_byte == 8'hFB)
        begin
            rx = {};
            in_frame = 1'b1;
            gap_last = gap;
        end
        if (in_frame) rx.push_back({tx_byte_ctrl, tx_byte});
        if (tx_byte_ctrl && tx_byte == 8'hFD)
        begin
            in_frame = 1'b0;
            frames++;
            gap = 0;
        end
        else if (!in_frame && tx_byte_ctrl && tx_byte == 8'h07) gap++;
    end

    // Reflected CRC, one byte at a time
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
        c = c ^ {24'h000000, d};
        repeat (8) c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
        return c;
    endfunction : crc_step

    // Expected stream: preamble, bytes, pad, CRC low byte first, terminate
    function automatic void build_exp(input int len, input logic [7:0] base, input int bad,
        input bit inb);
        logic [31:0] crc;
        logic [7:0] d;
        int tot, k;
        exq = {9'h1FB};
        repeat (6) exq.push_back(9'h055);
        exq.push_back(9'h0D5);
        crc = 32'hFFFFFFFF;
        tot = inb ? 64 : 60;
        if (len > tot) tot = len;
        for (k = 0; k < tot; k++)
        begin
            d = (k < len) ? 8'(base + 7*k) : 8'h00;
            crc = crc_step(crc, d);
            exq.push_back((bad >= 0 && k >= 8*bad && k < len) ? 9'h1FE : {1'b0, d});
        end
        if (!inb)
            for (k = 0; k < 4; k++)
                exq.push_back(bad >= 0 ? 9'h1FE : {1'b0, 8'(~crc >> 8*k)});
        exq.push_back(9'h1FD);
    endfunction : build_exp

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    // Send one frame, wait for it on the line, compare every byte
    task automatic run_frame(input int len, input int bad, input bit inb, input int gmin);
        int f0, n, k;
        logic [7:0] base;
        base = 8'($urandom);
        build_exp(len, base, bad, inb);
        f0 = frames;
        PEER.send(len, base, bad);
        n = 0;
        while (frames == f0 && n < 4000)
        begin
            @(negedge ref_clk);
            n++;
        end
        `CHK("timeout", 1'b0, PEER.timed_out || n >= 4000)
        if (n >= 4000) report_and_stop();
        `CHK("length", exq.size(), rx.size())
        for (k = 0; k < exq.size() && k < rx.size(); k++)
            `CHK("byte", exq[k], rx[k])
        if (gmin > 0)
            `CHK("gap", 1'b1, gap_last >= gmin && gap_last <= gmin + 3)
    endtask : run_frame

    initial
    begin
        nrst = 1'b0;
        idle_deficit_averaging = 1'b0;
        inband_fcs_en = 1'b0;
        ifg_adjust_en = 1'b0;
        tx_ifg_delay = 8'h00;
        void'($urandom(32'h954F113C));
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        // Shortest header-only frame, padded
        run_frame(14, -1, 1'b0, 0);
        for (i = 0; i < 6; i++)
            run_frame($urandom_range(120, 15), -1, 1'b0, 12);
        // Client FCS mode: short frame padded after it, long frame untouched
        @(posedge ref_clk);
        inband_fcs_en <= 1'b1;
        run_frame(30, -1, 1'b1, 0);
        run_frame(70, -1, 1'b1, 0);
        @(posedge ref_clk);
        inband_fcs_en <= 1'b0;
        // Explicit underrun in the third word
        run_frame(80, 2, 1'b0, 0);
        // Long frame fills the buffer until ready drops
        saw_full = 1'b0;
        run_frame(200, -1, 1'b0, 0);
        `CHK("full", 1'b1, saw_full)
        // Stretched gap of five columns
        @(posedge ref_clk);
        ifg_adjust_en <= 1'b1;
        tx_ifg_delay <= 8'h05;
        run_frame(64, -1, 1'b0, 20);
        // Let the full gap after the last frame run out before shortening is allowed
        repeat (16) @(posedge ref_clk);
        ifg_adjust_en <= 1'b0;
        idle_deficit_averaging <= 1'b1;
        for (i = 0; i < 3; i++)
            run_frame($urandom_range(90, 40), -1, 1'b0, 0);
        // Second reset mid-run
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        `CHK("idle", 9'h107, {tx_byte_ctrl, tx_byte})
        `CHK("ready", 1'b1, tx_axis_tready)
        run_frame(40, -1, 1'b0, 0);
        report_and_stop();
    end
endmodule : eth_mac_tx_stream_client_tb
